// ### rtl/scgn_sysctl.sv
// Purpose: clock gating, clock output and supply noise register bank
// Assumes: APB slave, zero wait states after setup, pins sync to pclk
// Notes: clock output resamples its source on pclk, so sources near
// or above half the bus rate come out aliased
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps

module scgn_sysctl #(
  parameter int GATE_W = scgn_pkg::DATA_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scgn_pkg::ADDR_W-1:0] paddr,
  input wire logic [scgn_pkg::DATA_W-1:0] pwdata,
  input wire logic [scgn_pkg::STRB_W-1:0] pstrb,
  output logic [scgn_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_supply_noise_det,
  input wire logic core_supply_noise_det,
  output logic supply_noise_interrupt,
  output logic [scgn_pkg::TRANS_W-1:0] transient_immunity_level,
  output logic [GATE_W-1:0] periph_clock_gate,
  input wire logic internal_slow_oscillator,
  input wire logic external_slow_crystal,
  input wire logic internal_fast_oscillator,
  input wire logic external_fast_crystal,
  output logic clock_out_pin,
  output logic clock_out_pin_oe,
  output logic clock_out_pin_takeover,
  input wire logic [scgn_pkg::IDX_W-1:0] periph_rd_index,
  input wire logic [scgn_pkg::DATA_W-1:0] periph_rdata_raw,
  output logic [scgn_pkg::DATA_W-1:0] periph_rdata
);

  typedef struct packed {
    scgn_pkg::scgn_apb_state_t st;
    logic [scgn_pkg::DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
    logic [GATE_W-1:0] gate;
    logic [scgn_pkg::NOISE_W-1:0] noise_en;
    logic [scgn_pkg::TRANS_W-1:0] transient;
    logic irq;
    logic bus_div;
    logic clk_out;
    logic clk_oe;
    logic takeover;
    logic [scgn_pkg::DATA_W-1:0] periph_rdata;
  } scgn_state_t;

  localparam scgn_state_t RESET_STATE = '{
    st: scgn_pkg::ST_IDLE,
    rdata: '0,
    ready: 1'b0,
    slverr: 1'b0,
    gate: scgn_pkg::CLK_GATE_RESET[GATE_W-1:0],
    noise_en: scgn_pkg::NOISE_EN_RESET,
    transient: scgn_pkg::TI_NONE,
    irq: 1'b0,
    bus_div: 1'b0,
    clk_out: 1'b0,
    clk_oe: 1'b0,
    takeover: 1'b0,
    periph_rdata: '0
  };

  scgn_state_t state_ff;
  scgn_state_t nxt_state;

  logic [scgn_pkg::NOISE_W-1:0] noise_flags;
  logic [scgn_pkg::NOISE_W-1:0] noise_set;
  logic [scgn_pkg::NOISE_W-1:0] noise_clr;
  logic wr_access;
  logic setup_phase;
  logic [scgn_pkg::SEL_W-1:0] clk_out_sel;
  logic [scgn_pkg::DATA_W-1:0] noise_en_wide;
  logic [scgn_pkg::DATA_W-1:0] transient_wide;

  // byte-lane merge restricted to the implemented bits of a register
  function automatic logic [scgn_pkg::DATA_W-1:0] merge_lanes(
    input logic [scgn_pkg::DATA_W-1:0] old_val,
    input logic [scgn_pkg::DATA_W-1:0] new_val,
    input logic [scgn_pkg::STRB_W-1:0] strb,
    input logic [scgn_pkg::DATA_W-1:0] mask
  );
    logic [scgn_pkg::DATA_W-1:0] lane_mask;
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lane_mask = lane_mask & mask;
    return ((old_val & ~lane_mask) | (new_val & lane_mask)) & mask;
  endfunction : merge_lanes

  function automatic logic is_mapped(input logic [scgn_pkg::ADDR_W-1:0] a);
    return (a == scgn_pkg::OFF_CLK_GATE) ||
           (a == scgn_pkg::OFF_NOISE_CTRL) ||
           (a == scgn_pkg::OFF_NOISE_STAT) ||
           (a == scgn_pkg::OFF_TRANSIENT) ||
           (a == scgn_pkg::OFF_NOISE_CLR);
  endfunction : is_mapped

  assign setup_phase = psel && !penable && (state_ff.st == scgn_pkg::ST_IDLE);
  assign wr_access = psel && penable && pwrite && state_ff.ready &&
                     is_mapped(paddr);
  assign clk_out_sel =
    state_ff.gate[scgn_pkg::CLK_OUT_SRC_MSB:scgn_pkg::CLK_OUT_SRC_LSB];
  // writes merge at full width, then only the implemented bits are kept
  assign noise_en_wide = merge_lanes(
    {{(scgn_pkg::DATA_W-scgn_pkg::NOISE_W){1'b0}}, state_ff.noise_en},
    pwdata, pstrb, scgn_pkg::NOISE_MASK);
  assign transient_wide = merge_lanes(
    {{(scgn_pkg::DATA_W-scgn_pkg::TRANS_W){1'b0}}, state_ff.transient},
    pwdata, pstrb, scgn_pkg::TRANS_MASK);

  assign noise_set[scgn_pkg::MAIN_NOISE_BIT] = main_supply_noise_det;
  assign noise_set[scgn_pkg::CORE_NOISE_BIT] = core_supply_noise_det;

  // status accepts write-one-to-clear, the clear word does the same
  always_comb begin
    noise_clr = '0;
    if (wr_access && pstrb[0]) begin
      if (paddr == scgn_pkg::OFF_NOISE_STAT) begin
        noise_clr = pwdata[scgn_pkg::NOISE_W-1:0];
      end else if (paddr == scgn_pkg::OFF_NOISE_CLR) begin
        noise_clr = pwdata[scgn_pkg::NOISE_W-1:0];
      end
    end
  end

  scgn_sticky_flags #(
    .N(scgn_pkg::NOISE_W)
  ) u_noise_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(noise_set),
    .clr_req(noise_clr),
    .flags(noise_flags)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_state.bus_div = ~state_ff.bus_div;

    case (state_ff.st)
      scgn_pkg::ST_IDLE: begin
        nxt_state.ready = 1'b0;
        nxt_state.slverr = 1'b0;
        if (setup_phase) begin
          nxt_state.st = scgn_pkg::ST_ANSWER;
          nxt_state.ready = 1'b1;
          nxt_state.rdata = '0;
          if (paddr == scgn_pkg::OFF_CLK_GATE) begin
            nxt_state.rdata[GATE_W-1:0] = state_ff.gate;
          end else if (paddr == scgn_pkg::OFF_NOISE_CTRL) begin
            nxt_state.rdata[scgn_pkg::NOISE_W-1:0] = state_ff.noise_en;
          end else if (paddr == scgn_pkg::OFF_NOISE_STAT) begin
            nxt_state.rdata[scgn_pkg::NOISE_W-1:0] = noise_flags;
          end else if (paddr == scgn_pkg::OFF_TRANSIENT) begin
            nxt_state.rdata[scgn_pkg::TRANS_W-1:0] = state_ff.transient;
          end else if (paddr == scgn_pkg::OFF_NOISE_CLR) begin
            nxt_state.rdata = '0;
          end else begin
            nxt_state.slverr = 1'b1;
          end
        end
      end
      scgn_pkg::ST_ANSWER: begin
        // access phase is always taken here, so the answer lasts one cycle
        nxt_state.st = scgn_pkg::ST_IDLE;
        nxt_state.ready = 1'b0;
        nxt_state.slverr = 1'b0;
        nxt_state.rdata = '0;
      end
      default: begin
        nxt_state.st = scgn_pkg::ST_IDLE;
        nxt_state.ready = 1'b0;
        nxt_state.slverr = 1'b0;
      end
    endcase

    if (wr_access) begin
      if (paddr == scgn_pkg::OFF_CLK_GATE) begin
        nxt_state.gate = merge_lanes(state_ff.gate, pwdata, pstrb,
                                     scgn_pkg::CLK_GATE_MASK);
      end else if (paddr == scgn_pkg::OFF_NOISE_CTRL) begin
        nxt_state.noise_en = noise_en_wide[scgn_pkg::NOISE_W-1:0];
      end else if (paddr == scgn_pkg::OFF_TRANSIENT) begin
        // unlisted codes are stored as written; the analog side decides
        nxt_state.transient = transient_wide[scgn_pkg::TRANS_W-1:0];
      end
    end

    // interrupt follows the enabled flags one cycle later
    nxt_state.irq = |(noise_flags & state_ff.noise_en);

    // hardware takes the pin from port io whenever a source is chosen
    nxt_state.takeover = (clk_out_sel != scgn_pkg::CO_DISABLED);
    nxt_state.clk_oe = (clk_out_sel != scgn_pkg::CO_DISABLED);
    case (clk_out_sel)
      scgn_pkg::CO_SLOW_OSC: nxt_state.clk_out = internal_slow_oscillator;
      scgn_pkg::CO_SLOW_XTAL: nxt_state.clk_out = external_slow_crystal;
      // a flop cannot pass pclk itself, so the bus clock leaves halved
      scgn_pkg::CO_BUS_CLOCK: nxt_state.clk_out = state_ff.bus_div;
      scgn_pkg::CO_FAST_OSC: nxt_state.clk_out = internal_fast_oscillator;
      scgn_pkg::CO_FAST_XTAL: nxt_state.clk_out = external_fast_crystal;
      default: nxt_state.clk_out = 1'b0;
    endcase

    // peripheral read data is forced to zero while its clock is off
    if (state_ff.gate[periph_rd_index]) begin
      nxt_state.periph_rdata = periph_rdata_raw;
    end else begin
      nxt_state.periph_rdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RESET_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = state_ff.rdata;
  assign pready = state_ff.ready;
  assign pslverr = state_ff.slverr;
  assign supply_noise_interrupt = state_ff.irq;
  assign transient_immunity_level = state_ff.transient;
  assign periph_clock_gate = state_ff.gate;
  assign clock_out_pin = state_ff.clk_out;
  assign clock_out_pin_oe = state_ff.clk_oe;
  assign clock_out_pin_takeover = state_ff.takeover;
  assign periph_rdata = state_ff.periph_rdata;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  irq_main_a: assert property (
    (noise_flags[scgn_pkg::MAIN_NOISE_BIT] &&
     state_ff.noise_en[scgn_pkg::MAIN_NOISE_BIT]) |=> supply_noise_interrupt)
    else $error("main supply noise did not raise interrupt");

  irq_core_a: assert property (
    (noise_flags[scgn_pkg::CORE_NOISE_BIT] &&
     state_ff.noise_en[scgn_pkg::CORE_NOISE_BIT]) |=> supply_noise_interrupt)
    else $error("core supply noise did not raise interrupt");

  main_flag_hold_a: assert property (
    (noise_flags[scgn_pkg::MAIN_NOISE_BIT] &&
     !noise_clr[scgn_pkg::MAIN_NOISE_BIT]) |=>
    noise_flags[scgn_pkg::MAIN_NOISE_BIT])
    else $error("main supply flag dropped without clear");

  core_flag_set_a: assert property (
    core_supply_noise_det |=> noise_flags[scgn_pkg::CORE_NOISE_BIT] ##1
    (noise_flags[scgn_pkg::CORE_NOISE_BIT] ||
     $past(noise_clr[scgn_pkg::CORE_NOISE_BIT])))
    else $error("core supply flag not held after event");

  transient_wr_a: assert property (
    (wr_access && (paddr == scgn_pkg::OFF_TRANSIENT) && pstrb[0]) |=>
    (transient_immunity_level == $past(pwdata[scgn_pkg::TRANS_W-1:0])))
    else $error("transient level write not stored");

  gate_wr_a: assert property (
    (wr_access && (paddr == scgn_pkg::OFF_CLK_GATE) && (pstrb == 4'hf)) |=>
    (periph_clock_gate == ($past(pwdata) & scgn_pkg::CLK_GATE_MASK)))
    else $error("clock gate write not applied");

  periph_zero_a: assert property (
    !state_ff.gate[periph_rd_index] |=> (periph_rdata == '0))
    else $error("gated peripheral read not zero");

  takeover_a: assert property (
    (clk_out_sel != scgn_pkg::CO_DISABLED) |=>
    (clock_out_pin_takeover && clock_out_pin_oe))
    else $error("clock output did not take over pin");

  clk_out_off_a: assert property (
    (clk_out_sel == scgn_pkg::CO_DISABLED) |=>
    (!clock_out_pin && !clock_out_pin_oe))
    else $error("disabled clock output still active");

  wdog_reset_a: assert property (
    $rose(presetn) |-> periph_clock_gate[scgn_pkg::WATCHDOG_GATE_BIT])
    else $error("watchdog clock not enabled after reset");

  port_reset_a: assert property (
    $rose(presetn) |-> periph_clock_gate[scgn_pkg::PORT_IO_GATE_BIT])
    else $error("port io clock not enabled after reset");

  others_reset_a: assert property (
    $rose(presetn) |-> (periph_clock_gate == scgn_pkg::CLK_GATE_RESET))
    else $error("clock gate reset value wrong");

  reserved_zero_a: assert property (
    (pready && !pslverr) |->
    (((paddr == scgn_pkg::OFF_CLK_GATE) &&
      ((prdata & ~scgn_pkg::CLK_GATE_MASK) == '0)) ||
     ((paddr != scgn_pkg::OFF_CLK_GATE) &&
      ((prdata & ~scgn_pkg::TRANS_MASK) == '0))))
    else $error("reserved bits read nonzero");

  irq_clear_a: assert property (
    ((noise_flags & state_ff.noise_en) == '0) |=> !supply_noise_interrupt)
    else $error("interrupt high with no enabled flag");

  transient_reset_a: assert property (
    $rose(presetn) |-> (transient_immunity_level == scgn_pkg::TI_NONE))
    else $error("transient level not none after reset");

  main_flag_set_a: assert property (
    main_supply_noise_det |=> noise_flags[scgn_pkg::MAIN_NOISE_BIT])
    else $error("main supply flag not set by event");

  periph_pass_a: assert property (
    state_ff.gate[periph_rd_index] |=>
    (periph_rdata == $past(periph_rdata_raw)))
    else $error("clocked peripheral read data not passed");

  cover_irq_c: cover property ($rose(supply_noise_interrupt));
  cover_takeover_c: cover property ($rose(clock_out_pin_takeover));
  cover_w1c_c: cover property (
    noise_flags[scgn_pkg::MAIN_NOISE_BIT] ##1
    !noise_flags[scgn_pkg::MAIN_NOISE_BIT]);
  cover_slverr_c: cover property (pready && pslverr);

endmodule : scgn_sysctl

// ### rtl/scgn_pkg.sv
// Purpose: shared constants and types of the system control bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses within the bank
package scgn_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NOISE_W = 2;
  localparam int TRANS_W = 3;
  localparam int SEL_W = 3;
  localparam int IDX_W = 5;
  localparam int STRB_W = 4;

  localparam logic [ADDR_W-1:0] OFF_CLK_GATE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_NOISE_CTRL = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_NOISE_STAT = 12'h02c;
  localparam logic [ADDR_W-1:0] OFF_TRANSIENT = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_NOISE_CLR = 12'h034;

  // writable bits of the clock gating word; the rest read zero
  localparam logic [DATA_W-1:0] CLK_GATE_MASK = 32'h71f3_3fe7;
  // watchdog and port io clocks run out of reset
  localparam logic [DATA_W-1:0] CLK_GATE_RESET = 32'h0100_0001;
  localparam logic [DATA_W-1:0] NOISE_MASK = 32'h0000_0003;
  localparam logic [DATA_W-1:0] TRANS_MASK = 32'h0000_0007;
  localparam logic [NOISE_W-1:0] NOISE_EN_RESET = 2'h0;
  localparam logic [NOISE_W-1:0] NOISE_FLAG_RESET = 2'h0;

  localparam int CLK_OUT_SRC_LSB = 28;
  localparam int CLK_OUT_SRC_MSB = 30;
  localparam int WATCHDOG_GATE_BIT = 24;
  localparam int PORT_IO_GATE_BIT = 0;
  localparam int MAIN_NOISE_BIT = 1;
  localparam int CORE_NOISE_BIT = 0;

  typedef enum logic [TRANS_W-1:0] {
    TI_NONE = 3'h0,
    TI_LOW = 3'h2,
    TI_MEDIUM = 3'h3,
    TI_STRONG = 3'h4
  } scgn_transient_t;

  typedef enum logic [SEL_W-1:0] {
    CO_DISABLED = 3'h0,
    CO_SLOW_OSC = 3'h1,
    CO_SLOW_XTAL = 3'h2,
    CO_BUS_CLOCK = 3'h4,
    CO_FAST_OSC = 3'h5,
    CO_FAST_XTAL = 3'h6
  } scgn_clk_out_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } scgn_apb_state_t;

endpackage : scgn_pkg

// ### rtl/scgn_sticky_flags.sv
// Purpose: bank of sticky event flags with clear requests
// Assumes: set and clear are synchronous to pclk
// Notes: a set in the cycle of its clear keeps the flag high
`timescale 1ns/100ps
module scgn_sticky_flags #(
  parameter int N = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] set_evt,
  input wire logic [N-1:0] clr_req,
  output logic [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] flags;
  } scgn_flag_state_t;

  scgn_flag_state_t state_ff;
  scgn_flag_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    // set wins over clear so no event is lost
    nxt_state.flags = (state_ff.flags & ~clr_req) | set_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flags = state_ff.flags;

  set_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (set_evt != '0) |=> ((state_ff.flags & $past(set_evt)) == $past(set_evt)))
    else $error("sticky flag lost a set event");

endmodule : scgn_sticky_flags

// ### test/scgn_sysctl_tb_top.sv
// Purpose: self-checking bench for the system control register bank
// Assumes: zero wait state APB slave, sources and detectors driven here
// Notes: expectations are literals or table values from the register map, except the sampled bus clock level
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end end

module scgn_sysctl_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic main_det = 1'b0;
  logic core_det = 1'b0;
  logic supply_noise_interrupt;
  logic [2:0] transient_immunity_level;
  logic [31:0] periph_clock_gate;
  logic [3:0] src = 4'h0;
  logic clock_out_pin;
  logic clock_out_pin_oe;
  logic clock_out_pin_takeover;
  logic [4:0] periph_rd_index = 5'h00;
  logic [31:0] periph_rdata_raw = 32'h0;
  logic [31:0] periph_rdata;
  int errors = 0;
  int compares = 0;

  scgn_sysctl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_supply_noise_det(main_det), .core_supply_noise_det(core_det),
    .supply_noise_interrupt(supply_noise_interrupt),
    .transient_immunity_level(transient_immunity_level),
    .periph_clock_gate(periph_clock_gate),
    .internal_slow_oscillator(src[0]), .external_slow_crystal(src[1]),
    .internal_fast_oscillator(src[2]), .external_fast_crystal(src[3]),
    .clock_out_pin(clock_out_pin), .clock_out_pin_oe(clock_out_pin_oe),
    .clock_out_pin_takeover(clock_out_pin_takeover),
    .periph_rd_index(periph_rd_index),
    .periph_rdata_raw(periph_rdata_raw), .periph_rdata(periph_rdata)
  );

  always #12.5 pclk = ~pclk;

  task automatic end_sim;
    $display("counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one request waits a free edge first, so psel is never set twice at once
  task automatic apb(input logic wr_en, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rdata, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      $display("timeout waiting for pready at t=%0t", $time);
      end_sim();
    end else begin
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    `CHK(r, exp)
    `CHK(e, exp_err)
  endtask : rd_chk

  // one-cycle detector pulse
  task automatic pulse(input int b);
    @(posedge pclk);
    if (b == 1) main_det <= 1'b1;
    else core_det <= 1'b1;
    @(posedge pclk);
    main_det <= 1'b0;
    core_det <= 1'b0;
  endtask : pulse

  initial begin : main_seq
    logic [31:0] v;
    logic p0;
    int lvls [4] = '{0, 2, 3, 4};
    int sels [7] = '{0, 1, 2, 3, 4, 5, 6};
    int sbit [7] = '{0, 0, 1, 0, 0, 2, 3};
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    rd_chk(12'h000, 32'h0100_0001);
    `CHK(periph_clock_gate, 32'h0100_0001)
    rd_chk(12'h028, 32'h0);
    rd_chk(12'h02c, 32'h0);
    rd_chk(12'h030, 32'h0);
    `CHK(transient_immunity_level, 3'h0)
    $display("test reset values done");
    wr(12'h000, 32'hffff_ffff);
    rd_chk(12'h000, 32'h71f3_3fe7);
    `CHK(periph_clock_gate, 32'h71f3_3fe7)
    wr(12'h000, 32'h0);
    rd_chk(12'h000, 32'h0);
    wr(12'h000, 32'hffff_ffff, 4'h1);
    rd_chk(12'h000, 32'h0000_00e7);
    wr(12'h000, 32'h0000_0020);
    periph_rd_index <= 5'd5;
    periph_rdata_raw <= 32'h5a5a_a5a5;
    cyc(3);
    `CHK(periph_rdata, 32'h5a5a_a5a5)
    periph_rd_index <= 5'd6;
    cyc(3);
    `CHK(periph_rdata, 32'h0)
    $display("test clock gating done");
    for (int i = 0; i < 4; i++) begin
      wr(12'h030, 32'(lvls[i]));
      rd_chk(12'h030, 32'(lvls[i]));
      `CHK(transient_immunity_level, 3'(lvls[i]))
    end
    wr(12'h030, 32'hffff_fffc);
    rd_chk(12'h030, 32'h0000_0004);
    $display("test transient level done");
    for (int b = 0; b < 2; b++) begin
      v = 32'h1 << b;
      pulse(b);
      cyc(3);
      `CHK(supply_noise_interrupt, 1'b0)
      rd_chk(12'h02c, v);
      wr(12'h028, 32'h1 << (1 - b));
      cyc(3);
      `CHK(supply_noise_interrupt, 1'b0)
      wr(12'h028, v);
      cyc(3);
      `CHK(supply_noise_interrupt, 1'b1)
      wr(12'h02c, v, 4'h0);
      rd_chk(12'h02c, v);
      wr(12'h02c, v);
      cyc(3);
      `CHK(supply_noise_interrupt, 1'b0)
      rd_chk(12'h02c, 32'h0);
    end
    pulse(0);
    pulse(1);
    wr(12'h034, 32'h3);
    rd_chk(12'h034, 32'h0);
    rd_chk(12'h02c, 32'h0);
    rd_chk(12'h100, 32'h0, 1'b1);
    wr(12'h028, 32'h0);
    $display("test noise flags done");
    for (int i = 0; i < 7; i++) begin
      v = {1'b0, 3'(sels[i]), 28'h100_0001};
      wr(12'h000, v);
      cyc(3);
      `CHK(clock_out_pin_oe, 1'(sels[i] != 0))
      `CHK(clock_out_pin_takeover, 1'(sels[i] != 0))
      if (sels[i] == 4) begin
        p0 = clock_out_pin;
        cyc(1);
        `CHK(clock_out_pin, ~p0)
      end else if (sels[i] == 0 || sels[i] == 3) begin
        src <= 4'hf;
        cyc(4);
        `CHK(clock_out_pin, 1'b0)
      end else begin
        src <= 4'h1 << sbit[i];
        cyc(4);
        `CHK(clock_out_pin, 1'b1)
        src <= ~(4'h1 << sbit[i]);
        cyc(4);
        `CHK(clock_out_pin, 1'b0)
      end
    end
    $display("test clock output done");
    presetn <= 1'b0;
    cyc(3);
    `CHK(periph_clock_gate, 32'h0100_0001)
    `CHK(clock_out_pin_oe, 1'b0)
    `CHK(transient_immunity_level, 3'h0)
    presetn <= 1'b1;
    cyc(2);
    rd_chk(12'h000, 32'h0100_0001);
    rd_chk(12'h028, 32'h0);
    rd_chk(12'h030, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end : main_seq

  // whole run is far below this bound; reaching it means a hang
  initial begin : watchdog
    #1250000;
    errors++;
    $display("run limit reached at t=%0t", $time);
    end_sim();
  end : watchdog
endmodule : scgn_sysctl_tb_top
